/* File: spd_pkg.sv */
// Shared constants, types and command decoding for the power-state link
package spd_pkg;
	localparam int CLK_NS = 50;
	localparam int CNT_W  = 10;

	// Timing figures; ns values are converted to whole cycles, rounded up
	localparam int T_RP_NS  = 15;
	localparam int T_RFC_NS = 160;
	localparam int T_XS_NS  = 170;
	localparam logic [CNT_W-1:0] RP_CK  = 10'((T_RP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] RFC_CK = 10'((T_RFC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] XS_CK  = 10'((T_XS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] MRD_CK      = 10'h004;
	localparam logic [CNT_W-1:0] MOD_CK      = 10'h00C;
	localparam logic [CNT_W-1:0] MODE_WAIT_CK = (MOD_CK > MRD_CK) ? MOD_CK : MRD_CK;
	localparam logic [CNT_W-1:0] CKE_MIN_CK  = 10'h003;
	localparam logic [CNT_W-1:0] XSDLL_CK    = 10'h200;
	localparam logic [CNT_W-1:0] VREF_WR_CK  = 10'h200;
	localparam logic [CNT_W-1:0] BURST_CK    = 10'h004;

	// Mode register fields
	localparam int DLL_OFF_BIT = 0;
	localparam int AL_LSB      = 3;
	localparam int CL_LSB      = 4;
	localparam int CWL_LSB     = 3;
	localparam int AP_BIT      = 10;
	localparam logic [3:0] DLL_OFF_LAT = 4'h6;
	localparam logic [2:0] MR_SEL_ZERO = 3'h0;
	localparam logic [2:0] MR_SEL_ONE  = 3'h1;
	localparam logic [2:0] MR_SEL_TWO  = 3'h2;

	typedef enum logic [3:0] {
		CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
		CMD_WR  = 4'h4, CMD_RD  = 4'h5, CMD_ZQ  = 4'h6, CMD_NOP = 4'h7,
		CMD_DES = 4'h8
	} spd_cmd_t;

	typedef enum logic [1:0] {
		PWR_ON = 2'h0, PWR_APD = 2'h1, PWR_PPD = 2'h3, PWR_SREF = 2'h2
	} spd_pwr_t;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_ACT = 4'h1, OP_RD  = 4'h2, OP_WR  = 4'h3,
		OP_PRE = 4'h4, OP_REF = 4'h5, OP_MRS = 4'h6, OP_ZQ  = 4'h7,
		OP_PDE = 4'h8, OP_PDX = 4'h9, OP_SRE = 4'hA, OP_SRX = 4'hB
	} spd_op_t;

	// Chip select high wins over the strobes
	function automatic spd_cmd_t spd_decode(input logic cs_b, input logic [2:0] rcw);
		spd_cmd_t c;
		c = spd_cmd_t'({1'b0, rcw});
		return cs_b ? CMD_DES : c;
	endfunction : spd_decode
endpackage : spd_pkg

/* File: spd_link_if.sv */
// Command, clock-enable and strobe-mark wires between controller and device
`timescale 1ns/10ps
`default_nettype none
interface spd_link_if (
	input wire logic mclk,
	input wire logic rst_b
);
	logic        cke;
	logic        cs_b;
	logic        ras_b;
	logic        cas_b;
	logic        we_b;
	logic        on_die_termination_input;
	logic [2:0]  ba;
	logic [15:0] addr;
	logic        rd_strb_start;

	modport ctrl (input mclk, rst_b, rd_strb_start,
		output cke, cs_b, ras_b, cas_b, we_b, on_die_termination_input, ba, addr);
	modport dev (input mclk, rst_b, cke, cs_b, ras_b, cas_b, we_b, on_die_termination_input, ba, addr,
		output rd_strb_start);
endinterface : spd_link_if
`default_nettype wire

/* File: spd_wait_cnt.sv */
// Loadable down counter that flags when a wait has elapsed
`timescale 1ns/10ps
`default_nettype none
module spd_wait_cnt
	import spd_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_val,
	output logic                  done
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	assign cnt_nxt = load ? load_val : (done ? cnt_r : cnt_r - 10'h001);
	assign done    = (cnt_r == 10'h000);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 10'h000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : spd_wait_cnt
`default_nettype wire

/* File: spd_device.sv */
// Device end: clock-enable power states, command qualification, DLL-off read timing
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module spd_device
	import spd_pkg::*;
(
	spd_link_if.dev         link,
	output spd_pwr_t        pwr_state,
	output logic            dll_off,
	output logic            idle,
	output logic            refresh_active,
	output logic            odt_active,
	output logic            lat_unsupported,
	output logic            cmd_illegal,
	output logic            exec_valid,
	output spd_cmd_t        exec_cmd
);
	spd_pwr_t         pwr_r;
	spd_pwr_t         pwr_nxt;
	logic             cke_prev_r;
	logic [7:0]       open_r;
	logic [7:0]       open_nxt;
	logic [7:0]       ap_pend_r;
	logic [7:0]       ap_nxt;
	logic [CNT_W-1:0] pre_cnt_r;
	logic [CNT_W-1:0] rfc_cnt_r;
	logic [CNT_W-1:0] mod_cnt_r;
	logic [CNT_W-1:0] xs_cnt_r;
	logic [CNT_W-1:0] burst_cnt_r;
	logic [CNT_W-1:0] pre_nxt;
	logic [CNT_W-1:0] rfc_nxt;
	logic [CNT_W-1:0] mod_nxt;
	logic [CNT_W-1:0] xs_nxt;
	logic [CNT_W-1:0] burst_nxt;
	logic [15:0]      mr_r [0:2];
	logic [31:0]      sh_r;
	logic [31:0]      sh_nxt;
	logic             illegal_r;
	logic             exec_r;
	spd_cmd_t         exec_cmd_r;

	function automatic logic [CNT_W-1:0] cnt_dec(input logic [CNT_W-1:0] c);
		return (c == 10'h000) ? c : c - 10'h001;
	endfunction : cnt_dec

	spd_cmd_t   cmd;
	logic       cke_now;
	logic       fall;
	logic       rise;
	logic       hold_hi;
	logic       hold_lo;
	logic       nopdes;
	logic       pwr_on;
	logic       rw_busy;
	logic       idle_w;
	logic       sre_ok;
	logic       pde_ok;
	logic       exit_ok;
	logic       maintain;
	logic       run_ok;
	logic       exec;
	logic       is_rw;
	logic       is_rd;
	logic       burst_end;
	logic       closes_all;
	logic [7:0] bank_bit;
	logic [7:0] open_set;
	logic [7:0] open_clr;
	logic [7:0] ap_clr;
	logic [3:0] cl;
	logic [3:0] write_latency;
	logic [1:0] al;
	logic [5:0] rl_sum;
	logic [5:0] delay;
	logic [31:0] mark;

	assign cmd     = spd_decode(link.cs_b, {link.ras_b, link.cas_b, link.we_b});
	assign cke_now = link.cke;
	// Transitions come only from the previous and present enable samples
	assign fall    = cke_prev_r & ~cke_now;
	assign rise    = ~cke_prev_r & cke_now;
	assign hold_hi = cke_prev_r & cke_now;
	assign hold_lo = ~cke_prev_r & ~cke_now;
	assign nopdes  = (cmd == CMD_NOP) || (cmd == CMD_DES);
	assign pwr_on  = (pwr_r == PWR_ON);
	assign rw_busy = (burst_cnt_r != 10'h000);
	assign burst_end = (burst_cnt_r == 10'h001);

	assign idle_w = pwr_on && cke_prev_r && (open_r == 8'h00) && (pre_cnt_r == 10'h000)
		&& (rfc_cnt_r == 10'h000) && (mod_cnt_r == 10'h000) && (xs_cnt_r == 10'h000)
		&& !rw_busy;

	assign sre_ok   = fall && pwr_on && (cmd == CMD_REF) && idle_w && !rw_busy;
	assign pde_ok   = fall && pwr_on && nopdes;
	assign exit_ok  = rise && !pwr_on && nopdes;
	assign maintain = hold_lo && !pwr_on;
	assign run_ok   = hold_hi && pwr_on;
	// Anything outside the defined combinations is flagged and not acted on
	assign exec     = run_ok && !nopdes;

	assign is_rw    = exec && ((cmd == CMD_RD) || (cmd == CMD_WR));
	assign is_rd    = exec && (cmd == CMD_RD);
	assign bank_bit = 8'h01 << link.ba;
	assign closes_all = ((open_r & ~ap_pend_r) == 8'h00);

	assign pwr_nxt = sre_ok ? PWR_SREF
		: pde_ok ? (closes_all ? PWR_PPD : PWR_APD)
		: exit_ok ? PWR_ON
		: pwr_r;

	assign open_set = (exec && (cmd == CMD_ACT)) ? bank_bit : 8'h00;
	assign open_clr = (exec && (cmd == CMD_PRE)) ? (link.addr[AP_BIT] ? 8'hFF : bank_bit) : 8'h00;
	assign ap_clr   = burst_end ? ap_pend_r : 8'h00;
	assign open_nxt = (open_r | open_set) & ~open_clr & ~ap_clr;
	assign ap_nxt   = (burst_end ? 8'h00 : ap_pend_r)
		| ((is_rw && link.addr[AP_BIT]) ? bank_bit : 8'h00);

	// Timers keep running in power-down; only new commands are blocked
	assign pre_nxt   = ((exec && (cmd == CMD_PRE)) || (burst_end && (ap_pend_r != 8'h00)))
		? RP_CK : cnt_dec(pre_cnt_r);
	assign rfc_nxt   = (exec && (cmd == CMD_REF)) ? RFC_CK : cnt_dec(rfc_cnt_r);
	assign mod_nxt   = (exec && (cmd == CMD_MRS)) ? MOD_CK : cnt_dec(mod_cnt_r);
	assign xs_nxt    = (exit_ok && (pwr_r == PWR_SREF)) ? XS_CK : cnt_dec(xs_cnt_r);
	assign burst_nxt = is_rw ? BURST_CK : cnt_dec(burst_cnt_r);

	assign dll_off = mr_r[1][DLL_OFF_BIT];
	assign cl      = mr_r[0][CL_LSB +: 4];
	assign write_latency     = mr_r[2][CWL_LSB +: 4];
	assign al      = mr_r[1][AL_LSB +: 2];
	assign lat_unsupported = dll_off && ((cl != DLL_OFF_LAT) || (write_latency != DLL_OFF_LAT));

	// Only the clock-to-strobe start moves; strobe-to-data skew is untouched
	assign rl_sum = {4'h0, al} + {2'h0, cl};
	assign delay  = dll_off ? rl_sum - 6'h01 : rl_sum;
	assign mark   = (delay == 6'h00) ? 32'h0000_0001 : (32'h0000_0001 << (delay - 6'h01));
	assign sh_nxt = {1'b0, sh_r[31:1]} | (is_rd ? mark : 32'h0000_0000);

	assign pwr_state      = pwr_r;
	assign idle           = idle_w;
	// Refresh runs only from a refresh command or inside self refresh
	assign refresh_active = (pwr_r == PWR_SREF) || ((rfc_cnt_r != 10'h000) && pwr_on);
	assign odt_active     = link.on_die_termination_input && (pwr_r != PWR_SREF);
	assign cmd_illegal    = illegal_r;
	assign exec_valid     = exec_r;
	assign exec_cmd       = exec_cmd_r;
	assign link.rd_strb_start = sh_r[0];

	always_ff @(posedge link.mclk or negedge link.rst_b) begin
		if (!link.rst_b) begin
			pwr_r      <= PWR_ON;
			cke_prev_r <= 1'b1;
			open_r     <= 8'h00;
			ap_pend_r  <= 8'h00;
		end else begin
			pwr_r      <= pwr_nxt;
			cke_prev_r <= cke_now;
			open_r     <= open_nxt;
			ap_pend_r  <= ap_nxt;
		end
	end

	always_ff @(posedge link.mclk or negedge link.rst_b) begin
		if (!link.rst_b) begin
			pre_cnt_r   <= 10'h000;
			rfc_cnt_r   <= 10'h000;
			mod_cnt_r   <= 10'h000;
			xs_cnt_r    <= 10'h000;
			burst_cnt_r <= 10'h000;
		end else begin
			pre_cnt_r   <= pre_nxt;
			rfc_cnt_r   <= rfc_nxt;
			mod_cnt_r   <= mod_nxt;
			xs_cnt_r    <= xs_nxt;
			burst_cnt_r <= burst_nxt;
		end
	end

	always_ff @(posedge link.mclk or negedge link.rst_b) begin
		if (!link.rst_b) begin
			for (int i = 0; i < 3; i++) begin
				mr_r[i] <= 16'h0000;
			end
		end else if (exec && (cmd == CMD_MRS) && (link.ba <= MR_SEL_TWO)) begin
			mr_r[link.ba[1:0]] <= link.addr;
		end
	end

	always_ff @(posedge link.mclk or negedge link.rst_b) begin
		if (!link.rst_b) begin
			sh_r       <= 32'h0000_0000;
			illegal_r  <= 1'b0;
			exec_r     <= 1'b0;
			exec_cmd_r <= CMD_DES;
		end else begin
			sh_r       <= sh_nxt;
			illegal_r  <= !(sre_ok || pde_ok || exit_ok || maintain || run_ok);
			exec_r     <= exec;
			exec_cmd_r <= cmd;
		end
	end
endmodule : spd_device
`default_nettype wire

/* File: spd_ctrl.sv */
// Controller end: turns user operations into legal pin sequences
`timescale 1ns/10ps
`default_nettype none
module spd_ctrl
	import spd_pkg::*;
(
	spd_link_if.ctrl        link,
	input  wire logic       req_valid,
	input  wire spd_op_t    req_op,
	input  wire logic [2:0] req_ba,
	input  wire logic [15:0] req_addr,
	input  wire logic       req_odt,
	input  wire logic       vref_off,
	output logic            req_ready,
	output spd_pwr_t        cur_pwr,
	output logic            rd_strb_mark
);
	spd_pwr_t    pwr_r;
	spd_pwr_t    pwr_nxt;
	logic [7:0]  open_r;
	logic [7:0]  open_nxt;
	logic        dll_sh_r;
	logic        cke_r;
	logic [3:0]  pins_r;
	logic [2:0]  ba_r;
	logic [15:0] addr_r;
	logic        odt_r;

	logic        acc;
	logic        is_cke_op;
	logic        is_on_op;
	logic        lat_ok;
	logic        ok;
	logic        cke_z;
	logic        mode_z;
	logic        xs_z;
	logic        xl_z;
	logic        vr_z;
	logic        op_z;
	logic        op_load;
	logic [CNT_W-1:0] op_val;
	logic [7:0]  bank_bit;

	function automatic logic [3:0] op_pins(input spd_op_t o);
		case (o)
			OP_ACT:  return 4'h3;
			OP_RD:   return 4'h5;
			OP_WR:   return 4'h4;
			OP_PRE:  return 4'h2;
			OP_REF:  return 4'h1;
			OP_SRE:  return 4'h1;
			OP_MRS:  return 4'h0;
			OP_ZQ:   return 4'h6;
			OP_NOP:  return 4'h7;
			OP_PDE:  return 4'h7;
			OP_PDX:  return 4'h7;
			OP_SRX:  return 4'h7;
			default: return 4'hF;
		endcase
	endfunction : op_pins

	assign is_cke_op = (req_op == OP_PDE) || (req_op == OP_PDX)
		|| (req_op == OP_SRE) || (req_op == OP_SRX);
	assign is_on_op  = (req_op >= OP_ACT) && (req_op <= OP_ZQ);
	// While DLL-off, latency fields must stay at six
	assign lat_ok = !dll_sh_r
		|| ((req_ba == MR_SEL_ZERO) ? (req_addr[CL_LSB +: 4] == DLL_OFF_LAT)
		: (req_ba == MR_SEL_TWO) ? (req_addr[CWL_LSB +: 4] == DLL_OFF_LAT) : 1'b1);

	always_comb begin
		case (req_op)
			OP_NOP:  ok = 1'b1;
			OP_PDE:  ok = (pwr_r == PWR_ON) && cke_z && mode_z && xs_z;
			OP_SRE:  ok = (pwr_r == PWR_ON) && cke_z && mode_z && xs_z && op_z
				&& (open_r == 8'h00);
			OP_PDX:  ok = ((pwr_r == PWR_APD) || (pwr_r == PWR_PPD)) && cke_z;
			OP_SRX:  ok = (pwr_r == PWR_SREF) && cke_z;
			OP_RD:   ok = (pwr_r == PWR_ON) && xs_z && op_z && xl_z;
			OP_WR:   ok = (pwr_r == PWR_ON) && xs_z && op_z && vr_z;
			OP_MRS:  ok = (pwr_r == PWR_ON) && xs_z && op_z && mode_z && lat_ok;
			default: ok = is_on_op && (pwr_r == PWR_ON) && xs_z && op_z;
		endcase
	end

	assign req_ready = ok;
	assign acc       = req_valid && ok;
	assign bank_bit  = 8'h01 << req_ba;

	assign pwr_nxt = !acc ? pwr_r
		: (req_op == OP_PDE) ? ((open_r == 8'h00) ? PWR_PPD : PWR_APD)
		: (req_op == OP_SRE) ? PWR_SREF
		: ((req_op == OP_PDX) || (req_op == OP_SRX)) ? PWR_ON
		: pwr_r;
	assign open_nxt = !acc ? open_r
		: (req_op == OP_ACT) ? (open_r | bank_bit)
		: (req_op == OP_PRE) ? (req_addr[AP_BIT] ? 8'h00 : (open_r & ~bank_bit))
		: (((req_op == OP_RD) || (req_op == OP_WR)) && req_addr[AP_BIT])
			? (open_r & ~bank_bit)
		: open_r;

	assign op_load = acc && ((req_op == OP_RD) || (req_op == OP_WR)
		|| (req_op == OP_PRE) || (req_op == OP_REF));
	assign op_val  = (req_op == OP_PRE) ? RP_CK : (req_op == OP_REF) ? RFC_CK : BURST_CK;

	spd_wait_cnt u_cke (.mclk(link.mclk), .rst_b(link.rst_b),
		.load(acc && is_cke_op), .load_val(CKE_MIN_CK), .done(cke_z));
	spd_wait_cnt u_mode (.mclk(link.mclk), .rst_b(link.rst_b),
		.load(acc && (req_op == OP_MRS)), .load_val(MODE_WAIT_CK), .done(mode_z));
	spd_wait_cnt u_xs (.mclk(link.mclk), .rst_b(link.rst_b),
		.load(acc && (req_op == OP_SRX)), .load_val(XS_CK), .done(xs_z));
	spd_wait_cnt u_xl (.mclk(link.mclk), .rst_b(link.rst_b),
		.load(acc && (req_op == OP_SRX)), .load_val(XSDLL_CK), .done(xl_z));
	spd_wait_cnt u_vr (.mclk(link.mclk), .rst_b(link.rst_b),
		.load(acc && (req_op == OP_SRX) && vref_off), .load_val(VREF_WR_CK), .done(vr_z));
	spd_wait_cnt u_op (.mclk(link.mclk), .rst_b(link.rst_b),
		.load(op_load), .load_val(op_val), .done(op_z));

	// The clock period limit in DLL-off mode is left to whoever drives mclk
	assign cur_pwr      = pwr_r;
	assign rd_strb_mark = link.rd_strb_start;
	assign link.cke     = cke_r;
	assign link.cs_b    = pins_r[3];
	assign link.ras_b   = pins_r[2];
	assign link.cas_b   = pins_r[1];
	assign link.we_b    = pins_r[0];
	assign link.ba      = ba_r;
	assign link.addr    = addr_r;
	assign link.on_die_termination_input     = odt_r;

	always_ff @(posedge link.mclk or negedge link.rst_b) begin
		if (!link.rst_b) begin
			pwr_r    <= PWR_ON;
			open_r   <= 8'h00;
			dll_sh_r <= 1'b0;
			odt_r    <= 1'b0;
		end else begin
			pwr_r    <= pwr_nxt;
			open_r   <= open_nxt;
			dll_sh_r <= (acc && (req_op == OP_MRS) && (req_ba == MR_SEL_ONE))
				? req_addr[DLL_OFF_BIT] : dll_sh_r;
			// The exit edge itself still lies inside the locked-delay wait
			odt_r    <= req_odt && xl_z && (pwr_nxt == PWR_ON)
				&& !(acc && (req_op == OP_SRX));
		end
	end

	// Power-down entry and exit and self refresh exit go out with a NOP command beside them; self refresh entry with a refresh
	always_ff @(posedge link.mclk or negedge link.rst_b) begin
		if (!link.rst_b) begin
			cke_r  <= 1'b1;
			pins_r <= 4'hF;
			ba_r   <= 3'h0;
			addr_r <= 16'h0000;
		end else begin
			cke_r  <= (acc && ((req_op == OP_PDE) || (req_op == OP_SRE))) ? 1'b0
				: (acc && ((req_op == OP_PDX) || (req_op == OP_SRX))) ? 1'b1 : cke_r;
			pins_r <= acc ? op_pins(req_op) : 4'hF;
			ba_r   <= acc ? req_ba : ba_r;
			addr_r <= acc ? req_addr : addr_r;
		end
	end
endmodule : spd_ctrl
`default_nettype wire

/* File: spd_link_chk.sv */
// Concurrent checks on the wires between controller and device
`timescale 1ns/10ps
`default_nettype none
module spd_link_chk
	import spd_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        cke,
	input wire logic        cs_b,
	input wire logic        ras_b,
	input wire logic        cas_b,
	input wire logic        we_b,
	input wire logic        on_die_termination_input,
	input wire logic [2:0]  ba,
	input wire logic [15:0] addr,
	input wire logic        rd_strb_start
);
	wire       [2:0]  rcw     = {ras_b, cas_b, we_b};
	wire              nop_des = cs_b | (rcw == 3'h7);
	wire              is_rd   = !cs_b && (rcw == 3'h5);
	wire              is_wr   = !cs_b && (rcw == 3'h4);
	wire              is_ref  = !cs_b && (rcw == 3'h1);
	wire              is_mrs  = !cs_b && (rcw == 3'h0);
	logic             cke_q;
	logic             in_sr;
	logic             dll_r;
	logic      [3:0]  cl_r;
	logic      [1:0]  al_r;
	logic      [9:0]  srx_cnt;
	logic      [3:0]  mrs_cnt;
	logic      [31:0] exp_r;
	wire              sre     = cke_q & ~cke & is_ref;
	wire              srx     = ~cke_q & cke & in_sr;
	wire       [4:0]  lat_raw = 5'(cl_r) + 5'(al_r) - 5'(dll_r);
	wire       [4:0]  lat     = (lat_raw == 5'h00) ? 5'h01 : lat_raw;

	// Expected strobe marks travel down a shift register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cke_q <= 1'b1;
			in_sr <= 1'b0;
			dll_r <= 1'b0;
			cl_r <= 4'h0;
			al_r <= 2'h0;
			srx_cnt <= 10'h3FF;
			mrs_cnt <= 4'hF;
			exp_r <= 32'h0;
		end else begin
			cke_q <= cke;
			in_sr <= sre ? 1'b1 : (srx ? 1'b0 : in_sr);
			srx_cnt <= srx ? 10'h000 : ((srx_cnt == 10'h3FF) ? srx_cnt : srx_cnt + 10'h001);
			mrs_cnt <= is_mrs ? 4'h0 : ((mrs_cnt == 4'hF) ? mrs_cnt : mrs_cnt + 4'h1);
			exp_r <= (exp_r >> 1) | (is_rd ? (32'h1 << (lat - 5'h01)) : 32'h0);
			if (is_mrs && ba == MR_SEL_ZERO)
				cl_r <= addr[CL_LSB +: 4];
			if (is_mrs && ba == MR_SEL_ONE) begin
				al_r <= addr[AL_LSB +: 2];
				dll_r <= addr[DLL_OFF_BIT];
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence quiet_seq;
		nop_des [*3];
	endsequence
	sequence no_sre_seq;
		!sre [*3];
	endsequence

	pde_cmd_a: assert property ((cke_q && !cke) |-> (nop_des || is_ref))
		else $error("clock enable fell beside a wrong command");
	wake_cmd_a: assert property ((!cke_q && cke) |-> nop_des)
		else $error("clock enable rose beside a wrong command");
	cke_hold_a: assert property ($changed(cke) |=> $stable(cke) [*2])
		else $error("clock enable pulse too short");
	srx_quiet_a: assert property (srx |=> quiet_seq)
		else $error("command issued during self refresh exit wait");
	rd_locked_a: assert property ((is_rd || on_die_termination_input) |-> (srx_cnt >= 10'd511))
		else $error("read or termination too soon after self refresh exit");
	sre_busy_a: assert property ((is_rd || is_wr) |=> no_sre_seq)
		else $error("self refresh entry during an access");
	mode_wait_a: assert property ((cke_q && !cke) |-> (mrs_cnt >= 4'd11))
		else $error("clock enable low too soon after mode set");
	strobe_time_a: assert property (rd_strb_start == exp_r[0])
		else $error("read strobe mark at the wrong edge");
endmodule : spd_link_chk
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench joining controller and device ends
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import spd_pkg::*;
;
	logic        mclk, rst_b, req_valid, req_odt, vref_off, req_ready, rd_strb_mark;
	logic        dll_off, idle, refresh_active, odt_active, lat_unsupported;
	logic        cmd_illegal, exec_valid;
	spd_op_t     req_op;
	logic [2:0]  req_ba, bk;
	logic [15:0] req_addr;
	spd_pwr_t    pwr_state, cur_pwr;
	spd_cmd_t    exec_cmd;
	spd_cmd_t    exp_q[$];
	int          num_errors, samples_checked, seed, n;
	longint      t0;

	spd_link_if spd_link_if_i (.mclk(mclk), .rst_b(rst_b));
	spd_ctrl spd_ctrl_i (.link(spd_link_if_i), .req_valid(req_valid), .req_op(req_op),
		.req_ba(req_ba), .req_addr(req_addr), .req_odt(req_odt), .vref_off(vref_off),
		.req_ready(req_ready), .cur_pwr(cur_pwr), .rd_strb_mark(rd_strb_mark));
	spd_device spd_device_i (.link(spd_link_if_i), .pwr_state(pwr_state), .dll_off(dll_off),
		.idle(idle), .refresh_active(refresh_active), .odt_active(odt_active),
		.lat_unsupported(lat_unsupported), .cmd_illegal(cmd_illegal),
		.exec_valid(exec_valid), .exec_cmd(exec_cmd));
	spd_link_chk spd_link_chk_i (.mclk(mclk), .rst_b(rst_b), .cke(spd_link_if_i.cke),
		.cs_b(spd_link_if_i.cs_b), .ras_b(spd_link_if_i.ras_b), .cas_b(spd_link_if_i.cas_b),
		.we_b(spd_link_if_i.we_b), .on_die_termination_input(spd_link_if_i.on_die_termination_input), .ba(spd_link_if_i.ba),
		.addr(spd_link_if_i.addr), .rd_strb_start(spd_link_if_i.rd_strb_start));

	task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : cmp

	task automatic wrap_up;
		$display("checked=%0d errors=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// Hold the request until ready is seen, then release after the taking edge
	task automatic do_op(input spd_op_t op, input logic [2:0] b, input logic [15:0] a);
		int k;
		k = 0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_op <= op;
		req_ba <= b;
		req_addr <= a;
		do begin
			@(negedge mclk);
			k++;
			if (k > 2000) begin
				num_errors++;
				wrap_up();
			end
		end while (req_ready !== 1'b1);
		@(posedge mclk);
		req_valid <= 1'b0;
		case (op)
			OP_ACT: exp_q.push_back(CMD_ACT);
			OP_RD: exp_q.push_back(CMD_RD);
			OP_WR: exp_q.push_back(CMD_WR);
			OP_PRE: exp_q.push_back(CMD_PRE);
			OP_REF: exp_q.push_back(CMD_REF);
			OP_MRS: exp_q.push_back(CMD_MRS);
			OP_ZQ: exp_q.push_back(CMD_ZQ);
			default: ;
		endcase
	endtask : do_op

	task automatic settle_pwr(input spd_pwr_t exp);
		repeat (3) @(negedge mclk);
		cmp(16'(pwr_state), 16'(exp));
		cmp(16'(cur_pwr), 16'(exp));
	endtask : settle_pwr

	// Edges from the taking edge of a read to its strobe mark
	task automatic strobe_gap(input int expk);
		int k;
		k = 1;
		@(negedge mclk);
		while (rd_strb_mark !== 1'b1 && k < 20) begin
			@(negedge mclk);
			k++;
		end
		cmp(16'(k), 16'(expk));
	endtask : strobe_gap

	always @(negedge mclk) begin
		if (exec_valid === 1'b1)
			cmp(16'(exec_cmd), (exp_q.size() > 0) ? 16'(exp_q.pop_front()) : 16'hFFFF);
		if (cmd_illegal !== 1'b0)
			cmp(16'(cmd_illegal), 16'h0000);
	end

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (100000) @(posedge mclk);
		num_errors++;
		wrap_up();
	end

	initial begin
		rst_b = 1'b0;
		req_valid = 1'b0;
		req_op = OP_NOP;
		req_ba = 3'h0;
		req_addr = 16'h0000;
		req_odt = 1'b1;
		vref_off = 1'b0;
		seed = 32'h5d0e;
		num_errors = 0;
		samples_checked = 0;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(negedge mclk);
		cmp(16'(pwr_state), 16'(PWR_ON));
		cmp(16'(idle), 16'h0001);
		cmp(16'(dll_off), 16'h0000);
		bk = 3'($random(seed));
		do_op(OP_MRS, MR_SEL_ZERO, 16'h0060);
		do_op(OP_MRS, MR_SEL_TWO, 16'h0030);
		do_op(OP_ACT, bk, 16'($random(seed)));
		do_op(OP_RD, bk, 16'($random(seed)) & 16'hFBFF);
		strobe_gap(7);
		do_op(OP_WR, bk, 16'($random(seed)) & 16'hFBFF);
		do_op(OP_PDE, 3'h0, 16'h0000);
		settle_pwr(PWR_APD);
		cmp(16'(refresh_active), 16'h0000);
		cmp(16'(idle), 16'h0000);
		do_op(OP_PDX, 3'h0, 16'h0000);
		settle_pwr(PWR_ON);
		do_op(OP_PRE, bk, 16'h0000);
		do_op(OP_PDE, 3'h0, 16'h0000);
		settle_pwr(PWR_PPD);
		cmp(16'(refresh_active), 16'h0000);
		do_op(OP_PDX, 3'h0, 16'h0000);
		settle_pwr(PWR_ON);
		do_op(OP_REF, 3'h0, 16'h0000);
		do_op(OP_ZQ, 3'h0, 16'h0000);
		do_op(OP_SRE, 3'h0, 16'h0000);
		settle_pwr(PWR_SREF);
		cmp(16'(odt_active), 16'h0000);
		cmp(16'(refresh_active), 16'h0001);
		@(posedge mclk);
		vref_off <= 1'b1;
		do_op(OP_SRX, 3'h0, 16'h0000);
		t0 = $time;
		settle_pwr(PWR_ON);
		do_op(OP_ACT, bk, 16'($random(seed)));
		do_op(OP_WR, bk, 16'($random(seed)) & 16'hFBFF);
		n = int'(($time - t0) / CLK_NS);
		cmp(16'(n >= 512), 16'h0001);
		do_op(OP_RD, bk, 16'($random(seed)) & 16'hFBFF);
		strobe_gap(7);
		do_op(OP_PRE, bk, 16'h0000);
		do_op(OP_MRS, MR_SEL_ONE, 16'h0001);
		repeat (2) @(negedge mclk);
		cmp(16'(dll_off), 16'h0001);
		cmp(16'(lat_unsupported), 16'h0000);
		do_op(OP_ACT, bk, 16'($random(seed)));
		do_op(OP_RD, bk, 16'($random(seed)) & 16'hFBFF);
		strobe_gap(1 + 0 + 6 - 1);
		do_op(OP_PRE, bk, 16'h0000);
		// With the DLL off only latency six may be programmed
		repeat (4) @(posedge mclk);
		req_op <= OP_MRS;
		req_ba <= MR_SEL_ZERO;
		req_addr <= 16'h0060;
		@(negedge mclk);
		cmp(16'(req_ready), 16'h0001);
		@(posedge mclk);
		req_addr <= 16'h0050;
		@(negedge mclk);
		cmp(16'(req_ready), 16'h0000);
		do_op(OP_MRS, MR_SEL_ONE, 16'h0000);
		repeat (2) @(negedge mclk);
		cmp(16'(dll_off), 16'h0000);
		do_op(OP_ACT, bk, 16'($random(seed)));
		do_op(OP_RD, bk, 16'($random(seed)) & 16'hFBFF);
		strobe_gap(7);
		repeat (10) @(negedge mclk);
		cmp(16'(exp_q.size()), 16'h0000);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
